/* verilog/css_defs.svh */
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CSS_CLK_PERIOD_NS    100
`define CSS_SOFT_RST_WAIT_NS 1000
// least time rounds up to whole cycles
`define CSS_SOFT_RST_CYCLES \
  ((`CSS_SOFT_RST_WAIT_NS + `CSS_CLK_PERIOD_NS - 1) / `CSS_CLK_PERIOD_NS)
`define CSS_ILAS_CYCLES      8
`define CSS_CAL_RUN_CYCLES   32
`define CSS_SYNC_HOLD_CYCLES 4

// ---------------------------------------------------------------
// control frame: 8 bit address, 8 bit data, msb first
// ---------------------------------------------------------------
`define CSS_FRAME_BITS       16

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define CSS_ADDR_SOFT_RESET  8'h00
`define CSS_ADDR_LINK_CTRL   8'h01
`define CSS_ADDR_CAL_CTRL    8'h02
`define CSS_ADDR_CHAN_MODE   8'h03
`define CSS_ADDR_LINK_MODE   8'h04
`define CSS_ADDR_MULTIFRAME  8'h05
`define CSS_ADDR_SYNC_SRC    8'h06
`define CSS_ADDR_CAL_CFG     8'h07
`define CSS_ADDR_OVR_CTRL    8'h08
`define CSS_ADDR_CAL_TRIG    8'h09

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CSS_BIT_ENABLE       0
`define CSS_BIT_BACKGROUND   0
`define CSS_BIT_OFFSET_CAL   1
`define CSS_LINK_MODE_W      5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CSS_RST_LINK_EN      1'b1
`define CSS_RST_CAL_EN       1'b1
`define CSS_RST_LINK_MODE    5'h00
`define CSS_RST_KM1          8'h1f
`define CSS_RST_CAL_CFG      2'h0

`endif

/* verilog/css_pkg.sv */
`default_nettype none
package css_pkg;

  // link transmitter states
  typedef enum logic [1:0] {
    css_link_off  = 2'b00,
    css_link_cgs  = 2'b01,
    css_link_ilas = 2'b10,
    css_link_data = 2'b11
  } css_link_state_type;

  // calibration states
  typedef enum logic [1:0] {
    css_cal_off  = 2'b00,
    css_cal_idle = 2'b01,
    css_cal_run  = 2'b10
  } css_cal_state_type;

  // host sequencer states
  typedef enum logic [1:0] {
    css_host_idle = 2'b00,
    css_host_send = 2'b01,
    css_host_wait = 2'b10,
    css_host_done = 2'b11
  } css_host_state_type;

endpackage
`default_nettype wire

/* verilog/css_link_if.sv */
`default_nettype none
interface css_link_if;
  import css_pkg::*;

  logic               ctl_frame;  // high while a control frame shifts
  logic               ctl_bit;    // control data, msb first
  logic               sync_se_n;  // single ended handshake, low = sync
  logic               ts_p;       // timestamp pair, p low n high = sync
  logic               ts_n;
  css_link_state_type link_state; // transmitter state seen by receiver

  modport device (
    input  ctl_frame,
    input  ctl_bit,
    input  sync_se_n,
    input  ts_p,
    input  ts_n,
    output link_state
  );

  modport host (
    output ctl_frame,
    output ctl_bit,
    output sync_se_n,
    output ts_p,
    output ts_n,
    input  link_state
  );

endinterface
`default_nettype wire

/* verilog/css_device.sv */
`include "css_defs.svh"
`default_nettype none
module css_device (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  css_link_if.device        link,
  input  wire logic         adc_over,
  output logic              link_enable,
  output logic              cal_enable,
  output logic              cal_busy,
  output logic              reset_busy,
  output logic              single_channel,
  output logic              overrange_enable,
  output logic              overrange_flag,
  output logic              sync_select,
  output logic              background_cal,
  output logic              offset_cal,
  output logic [4:0]        link_mode_select,
  output logic [7:0]        frames_per_multiframe_minus_one
);
  import css_pkg::*;

  logic [14:0]        shift;
  logic [4:0]         bit_cnt;
  logic               wr;
  logic [7:0]         wr_addr;
  logic [7:0]         wr_data;
  logic [3:0]         rst_cnt;
  logic               trig;
  logic               trig_rise;
  logic [5:0]         cal_cnt;
  logic [3:0]         ilas_cnt;
  logic               sync_req;
  css_cal_state_type  cal_state;
  css_link_state_type lstate;

  // -------------------------------------------------------------
  // control frame receiver
  // -------------------------------------------------------------
  // shift in bits; a partial frame is dropped when the frame ends
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift   <= 15'h0000;
      bit_cnt <= 5'h00;
      wr      <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr <= 1'b0;
      if (link.ctl_frame) begin
        shift <= {shift[13:0], link.ctl_bit};
        if (bit_cnt == 5'(`CSS_FRAME_BITS - 1)) begin
          bit_cnt <= 5'h00;
          wr      <= 1'b1;
          {wr_addr, wr_data} <= {shift, link.ctl_bit};
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end else begin
        bit_cnt <= 5'h00;
      end
    end
  end

  // -------------------------------------------------------------
  // soft reset hold
  // -------------------------------------------------------------
  // reset hold time
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt <= 4'h0;
    end else if (wr && wr_addr == `CSS_ADDR_SOFT_RESET &&
                 wr_data[`CSS_BIT_ENABLE] && rst_cnt == 4'h0) begin
      rst_cnt <= 4'(`CSS_SOFT_RST_CYCLES);
    end else if (rst_cnt != 4'h0) begin
      rst_cnt <= rst_cnt - 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_busy <= 1'b0;
    end else begin
      reset_busy <= (rst_cnt > 4'h1) || (wr && rst_cnt == 4'h0 &&
        wr_addr == `CSS_ADDR_SOFT_RESET && wr_data[`CSS_BIT_ENABLE]);
    end
  end

  // -------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------
  // writes during the reset hold are ignored, not queued
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_enable      <= `CSS_RST_LINK_EN;
      cal_enable       <= `CSS_RST_CAL_EN;
      single_channel   <= 1'b0;
      link_mode_select <= `CSS_RST_LINK_MODE;
      frames_per_multiframe_minus_one <= `CSS_RST_KM1;
      sync_select      <= 1'b0;
      {offset_cal, background_cal} <= `CSS_RST_CAL_CFG;
      overrange_enable <= 1'b0;
      trig             <= 1'b0;
    end else if (rst_cnt == 4'(`CSS_SOFT_RST_CYCLES)) begin
      link_enable      <= `CSS_RST_LINK_EN;
      cal_enable       <= `CSS_RST_CAL_EN;
      single_channel   <= 1'b0;
      link_mode_select <= `CSS_RST_LINK_MODE;
      frames_per_multiframe_minus_one <= `CSS_RST_KM1;
      sync_select      <= 1'b0;
      {offset_cal, background_cal} <= `CSS_RST_CAL_CFG;
      overrange_enable <= 1'b0;
      trig             <= 1'b0;
    end else if (wr && rst_cnt == 4'h0) begin
      case (wr_addr)
        `CSS_ADDR_LINK_CTRL: link_enable <= wr_data[`CSS_BIT_ENABLE];
        `CSS_ADDR_CAL_CTRL:  cal_enable  <= wr_data[`CSS_BIT_ENABLE];
        `CSS_ADDR_CHAN_MODE: begin
          if (!cal_enable && !link_enable)
            single_channel <= wr_data[`CSS_BIT_ENABLE];
        end
        `CSS_ADDR_LINK_MODE: begin
          if (!link_enable && !cal_enable)
            link_mode_select <= wr_data[`CSS_LINK_MODE_W-1:0];
        end
        `CSS_ADDR_MULTIFRAME: begin
          if (!link_enable)
            frames_per_multiframe_minus_one <= wr_data;
        end
        `CSS_ADDR_SYNC_SRC: begin
          if (!link_enable)
            sync_select <= wr_data[`CSS_BIT_ENABLE];
        end
        `CSS_ADDR_CAL_CFG: begin
          if (!cal_enable) begin
            background_cal <= wr_data[`CSS_BIT_BACKGROUND];
            offset_cal     <= wr_data[`CSS_BIT_OFFSET_CAL];
          end
        end
        `CSS_ADDR_OVR_CTRL: overrange_enable <= wr_data[`CSS_BIT_ENABLE];
        `CSS_ADDR_CAL_TRIG: trig <= wr_data[`CSS_BIT_ENABLE];
        default: ;
      endcase
    end
  end

  assign trig_rise = wr && rst_cnt == 4'h0 && !trig &&
                     wr_addr == `CSS_ADDR_CAL_TRIG &&
                     wr_data[`CSS_BIT_ENABLE];

  // -------------------------------------------------------------
  // calibration machine
  // -------------------------------------------------------------
  // a trigger while a run is going is ignored
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_state <= css_cal_off;
      cal_cnt   <= 6'h00;
      cal_busy  <= 1'b0;
    end else begin
      case (cal_state)
        css_cal_off: begin
          if (cal_enable)
            cal_state <= css_cal_idle;
        end
        css_cal_idle: begin
          if (!cal_enable) begin
            cal_state <= css_cal_off;
          end else if (trig_rise) begin
            cal_state <= css_cal_run;
            cal_cnt   <= 6'(`CSS_CAL_RUN_CYCLES - 1);
          end
        end
        css_cal_run: begin
          if (!cal_enable)
            cal_state <= css_cal_off;
          else if (cal_cnt == 6'h00)
            cal_state <= css_cal_idle;
          else
            cal_cnt <= cal_cnt - 6'h01;
        end
        default: cal_state <= css_cal_off;
      endcase
      cal_busy <= (cal_state == css_cal_idle && cal_enable && trig_rise) ||
                  (cal_state == css_cal_run && cal_enable &&
                   cal_cnt != 6'h00);
    end
  end

  // -------------------------------------------------------------
  // link transmitter
  // -------------------------------------------------------------
  // handshake source mux
  assign sync_req = sync_select ? (!link.ts_p && link.ts_n)
                                : !link.sync_se_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lstate   <= css_link_off;
      ilas_cnt <= 4'h0;
    end else if (!link_enable) begin
      lstate <= css_link_off;
    end else begin
      case (lstate)
        css_link_off: lstate <= css_link_cgs;
        css_link_cgs: begin
          if (!sync_req) begin
            lstate   <= css_link_ilas;
            ilas_cnt <= 4'(`CSS_ILAS_CYCLES - 1);
          end
        end
        css_link_ilas: begin
          if (sync_req)
            lstate <= css_link_cgs;
          else if (ilas_cnt == 4'h0)
            lstate <= css_link_data;
          else
            ilas_cnt <= ilas_cnt - 4'h1;
        end
        css_link_data: begin
          if (sync_req)
            lstate <= css_link_cgs;
        end
        default: lstate <= css_link_off;
      endcase
    end
  end

  assign link.link_state = lstate;

  // overrange flag only when enabled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      overrange_flag <= 1'b0;
    else
      overrange_flag <= overrange_enable && adc_over;
  end

endmodule // css_device
`default_nettype wire

/* verilog/css_host.sv */
`include "css_defs.svh"
`default_nettype none
// Notes on behaviour
// - start only once clock is stable
// - soft reset, then wait one microsecond
// - stop link before link settings
// - stop calibration before calibration settings
// - write link mode while both stopped
// - write frames per multiframe minus one
// - select single ended or timestamp handshake
// - write calibration mode and offset choice
// - re-enable calibration after its settings
// - then enable overrange detection
// - re-enable link with new settings
// - receiver drives handshake, transmitter follows it
// - trigger written zero then one
// - channel mode set by register only
module css_host (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  css_link_if.host          link,
  input  wire logic         clock_stable,
  input  wire logic         start,
  input  wire logic         rx_resync,
  input  wire logic [4:0]   cfg_link_mode,
  input  wire logic [8:0]   cfg_frames,
  input  wire logic         cfg_sync_select,
  input  wire logic         cfg_single_channel,
  input  wire logic         cfg_background,
  input  wire logic         cfg_offset,
  input  wire logic         cfg_overrange,
  output logic              busy,
  output logic              done,
  output logic              link_up
);
  import css_pkg::*;

  localparam logic [3:0] last_step = 4'd12;

  css_host_state_type state;
  logic [3:0]         step;
  logic [15:0]        frame;
  logic [4:0]         bit_cnt;
  logic [3:0]         wait_cnt;
  logic               ctl_frame;
  logic               ctl_bit;
  logic               sync_req_n;
  logic [2:0]         hold_cnt;
  logic               sync_se_n;
  logic               ts_p;
  logic               ts_n;

  // -------------------------------------------------------------
  // step table
  // -------------------------------------------------------------
  // fixed write order
  function automatic logic [15:0] step_word(input logic [3:0] s);
    logic [7:0] d;
    d = 8'h00;
    case (s)
      4'd0: step_word = {`CSS_ADDR_SOFT_RESET, 8'h01};
      4'd1: step_word = {`CSS_ADDR_LINK_CTRL, 8'h00};
      4'd2: step_word = {`CSS_ADDR_CAL_CTRL, 8'h00};
      4'd3: step_word = {`CSS_ADDR_CHAN_MODE, 7'h00, cfg_single_channel};
      4'd4: step_word = {`CSS_ADDR_LINK_MODE, 3'h0, cfg_link_mode};
      4'd5: begin
        d = 8'(cfg_frames - 9'h001);
        step_word = {`CSS_ADDR_MULTIFRAME, d};
      end
      4'd6: step_word = {`CSS_ADDR_SYNC_SRC, 7'h00, cfg_sync_select};
      4'd7: step_word = {`CSS_ADDR_CAL_CFG, 6'h00, cfg_offset,
                         cfg_background};
      4'd8: step_word = {`CSS_ADDR_CAL_CTRL, 8'h01};
      4'd9: step_word = {`CSS_ADDR_OVR_CTRL, 7'h00, cfg_overrange};
      4'd10: step_word = {`CSS_ADDR_LINK_CTRL, 8'h01};
      4'd11: step_word = {`CSS_ADDR_CAL_TRIG, 8'h00};
      4'd12: step_word = {`CSS_ADDR_CAL_TRIG, 8'h01};
      default: step_word = 16'h0000;
    endcase
  endfunction

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  // wait for stable clock
  // start is ignored while a sequence runs or the clock is unsettled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= css_host_idle;
      step     <= 4'h0;
      frame    <= 16'h0000;
      bit_cnt  <= 5'h00;
      wait_cnt <= 4'h0;
    end else begin
      case (state)
        css_host_idle: begin
          if (start && clock_stable) begin
            state   <= css_host_send;
            step    <= 4'h0;
            frame   <= step_word(4'h0);
            bit_cnt <= 5'h00;
          end
        end
        css_host_send: begin
          frame <= {frame[14:0], 1'b0};
          if (bit_cnt == 5'(`CSS_FRAME_BITS - 1)) begin
            bit_cnt <= 5'h00;
            if (step == 4'h0) begin
              state    <= css_host_wait;
              wait_cnt <= 4'(`CSS_SOFT_RST_CYCLES);
            end else if (step == last_step) begin
              state <= css_host_done;
            end else begin
              state <= css_host_wait;
              wait_cnt <= 4'h1;
            end
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        css_host_wait: begin
          // a gap of at least one idle cycle ends each frame
          if (wait_cnt <= 4'h1) begin
            state <= css_host_send;
            step  <= step + 4'h1;
            frame <= step_word(step + 4'h1);
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        css_host_done: begin
          if (start && clock_stable) begin
            state   <= css_host_send;
            step    <= 4'h0;
            frame   <= step_word(4'h0);
            bit_cnt <= 5'h00;
          end
        end
        default: state <= css_host_idle;
      endcase
    end
  end

  // frame pins and status, registered
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_frame <= 1'b0;
      ctl_bit   <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      ctl_frame <= (state == css_host_send);
      ctl_bit   <= (state == css_host_send) && frame[15];
      busy      <= (state == css_host_send) || (state == css_host_wait);
      done      <= (state == css_host_done);
    end
  end

  assign link.ctl_frame = ctl_frame;
  assign link.ctl_bit   = ctl_bit;

  // -------------------------------------------------------------
  // receiver handshake
  // -------------------------------------------------------------
  // receiver drives sync
  // sync is held until code groups have been seen for a few cycles,
  // so a glitch in the transmitter state does not release it early
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_req_n <= 1'b0;
      hold_cnt   <= 3'h0;
    end else if (rx_resync || link.link_state == css_link_off) begin
      sync_req_n <= 1'b0;
      hold_cnt   <= 3'h0;
    end else if (!sync_req_n) begin
      if (link.link_state != css_link_cgs) begin
        hold_cnt <= 3'h0;
      end else if (hold_cnt == 3'(`CSS_SYNC_HOLD_CYCLES - 1)) begin
        sync_req_n <= 1'b1;
      end else begin
        hold_cnt <= hold_cnt + 3'h1;
      end
    end
  end

  // route to chosen input
  // the unused input idles in its released level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_se_n <= 1'b0;
      ts_p      <= 1'b1;
      ts_n      <= 1'b0;
      link_up   <= 1'b0;
    end else begin
      sync_se_n <= cfg_sync_select ? 1'b1 : sync_req_n;
      ts_p      <= cfg_sync_select ? sync_req_n : 1'b1;
      ts_n      <= cfg_sync_select ? !sync_req_n : 1'b0;
      link_up   <= (link.link_state == css_link_data);
    end
  end

  assign link.sync_se_n = sync_se_n;
  assign link.ts_p      = ts_p;
  assign link.ts_n      = ts_n;

endmodule // css_host
`default_nettype wire

/* bench/css_link_asserts.sv */
`default_nettype none
module css_link_asserts (
  input wire logic                 core_clk,
  input wire logic                 reset_n,
  input wire logic                 ctl_frame,
  input wire logic                 sync_se_n,
  input wire logic                 ts_p,
  input wire logic                 ts_n,
  input var  css_pkg::css_link_state_type link_state,
  input wire logic                 sync_select
);
  timeunit 1ns;
  timeprecision 1ns;
  import css_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic [4:0] frame_len;
  logic       sel_req;
  logic       any_req;

  // request as the device sees it, by its own path choice
  assign sel_req = sync_select ? (!ts_p && ts_n) : !sync_se_n;
  assign any_req = !sync_se_n || (!ts_p && ts_n);

  // cycles the frame strobe has stood high so far
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) frame_len <= 5'h00;
    else if (ctl_frame) frame_len <= frame_len + 5'h01;
    else frame_len <= 5'h00;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // whole frames
  property p_frame_len; $fell(ctl_frame) |-> frame_len == 5'h10; endproperty
  property p_off_next;
    link_state == css_link_off |=>
      link_state inside {css_link_off, css_link_cgs};
  endproperty
  property p_off_req; link_state == css_link_off |-> ##[1:2] any_req;
  endproperty
  property p_cgs_hold;
    link_state == css_link_cgs && sel_req |=> link_state != css_link_ilas;
  endproperty
  property p_cgs_exit;
    link_state == css_link_cgs && !sel_req |-> ##[1:2]
      link_state inside {css_link_ilas, css_link_off};
  endproperty
  property p_ilas_len;
    link_state == css_link_ilas && $past(link_state) != css_link_ilas |->
      (link_state == css_link_ilas)[*8] ##1
      link_state inside {css_link_data, css_link_off};
  endproperty
  property p_data_req;
    link_state == css_link_data && sel_req |-> ##[1:2]
      link_state == css_link_cgs;
  endproperty
  property p_ts_pair; ts_p != ts_n; endproperty

  a_frame_len: assert property (p_frame_len)
    else $error("control frame length wrong");
  a_off_next: assert property (p_off_next)
    else $error("link left off wrongly");
  a_off_req: assert property (p_off_req)
    else $error("no request while link off");
  a_cgs_hold: assert property (p_cgs_hold)
    else $error("cgs left under request");
  a_cgs_exit: assert property (p_cgs_exit)
    else $error("cgs kept after release");
  a_ilas_len: assert property (p_ilas_len)
    else $error("ilas length wrong");
  a_data_req: assert property (p_data_req)
    else $error("request ignored in data");
  a_ts_pair: assert property (p_ts_pair)
    else $error("timestamp pair not complementary");

  c_ilas: cover property (link_state == css_link_ilas ##1
                          link_state == css_link_data);
  c_frame: cover property ($fell(ctl_frame));
  c_resync: cover property (link_state == css_link_data ##1
                            link_state == css_link_cgs);
  c_ts: cover property (!ts_p);
endmodule // css_link_asserts
`default_nettype wire

/* bench/converter_startup_sequencer_test.sv */
`default_nettype none
module converter_startup_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import css_pkg::*;

  logic       core_clk, reset_n, clock_stable, start, rx_resync, adc_over;
  logic [4:0] cfg_link_mode, link_mode_select;
  logic [8:0] cfg_frames;
  logic [7:0] frames_per_multiframe_minus_one;
  logic       cfg_sync_select, cfg_single_channel, cfg_background;
  logic       cfg_offset, cfg_overrange, busy, done, link_up;
  logic       link_enable, cal_enable, cal_busy, reset_busy, single_channel;
  logic       overrange_enable, overrange_flag, sync_select;
  logic       background_cal, offset_cal;
  int         err_total, checked, cycles, busy_cnt;

  css_link_if u_css_link_if ();
  css_device u_css_device (.core_clk(core_clk), .reset_n(reset_n),
    .link(u_css_link_if.device), .adc_over(adc_over),
    .link_enable(link_enable), .cal_enable(cal_enable),
    .cal_busy(cal_busy), .reset_busy(reset_busy),
    .single_channel(single_channel), .overrange_enable(overrange_enable),
    .overrange_flag(overrange_flag), .sync_select(sync_select),
    .background_cal(background_cal), .offset_cal(offset_cal),
    .link_mode_select(link_mode_select),
    .frames_per_multiframe_minus_one(frames_per_multiframe_minus_one));
  css_host u_css_host (.core_clk(core_clk), .reset_n(reset_n),
    .link(u_css_link_if.host), .clock_stable(clock_stable),
    .start(start), .rx_resync(rx_resync), .cfg_link_mode(cfg_link_mode),
    .cfg_frames(cfg_frames), .cfg_sync_select(cfg_sync_select),
    .cfg_single_channel(cfg_single_channel),
    .cfg_background(cfg_background), .cfg_offset(cfg_offset),
    .cfg_overrange(cfg_overrange), .busy(busy), .done(done),
    .link_up(link_up));
  css_link_asserts u_css_link_asserts (.core_clk(core_clk),
    .reset_n(reset_n), .ctl_frame(u_css_link_if.ctl_frame),
    .sync_se_n(u_css_link_if.sync_se_n), .ts_p(u_css_link_if.ts_p),
    .ts_n(u_css_link_if.ts_n), .link_state(u_css_link_if.link_state),
    .sync_select(sync_select));

  // ---------------------------------------------------------------
  // clock, watchdog and calibration busy counter
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // a hung handshake must still reach the verdict
  always @(negedge core_clk) begin
    cycles++;
    if (cal_busy === 1'b1) busy_cnt++;
    if (cycles == 6000) begin
      err_total++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [8:0] seen,
                       input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // flags: sync path, single channel, background, offset, overrange
  task automatic run_seq(input logic [4:0] mode, input logic [8:0] k,
                         input logic [4:0] flags);
    int n;
    int b0;
    int rb;
    {cfg_sync_select, cfg_single_channel, cfg_background, cfg_offset,
     cfg_overrange} = flags;
    cfg_link_mode = mode;
    cfg_frames = k;
    b0 = busy_cnt;
    rb = 0;
    @(negedge core_clk) start = 1'b1;
    @(negedge core_clk) start = 1'b0;
    // old done may still stand for a cycle or two
    repeat (3) @(negedge core_clk);
    check("busy", busy, 9'h001);
    // count the soft reset hold while the sequence runs
    for (n = 0; n < 2000 && done !== 1'b1; n++) begin
      @(negedge core_clk);
      if (reset_busy === 1'b1) rb++;
    end
    repeat (40) @(negedge core_clk);
    check("reset_hold", 9'(rb), 9'h00a);
    check("idle", busy, 9'h000);
    check("done", done, 9'h001);
    check("reset_busy", reset_busy, 9'h000);
    check("link_enable", link_enable, 9'h001);
    check("cal_enable", cal_enable, 9'h001);
    check("link_mode", link_mode_select, mode);
    check("km1", frames_per_multiframe_minus_one, k - 9'h001);
    check("sync_select", sync_select, flags[4]);
    check("single", single_channel, flags[3]);
    check("background", background_cal, flags[2]);
    check("offset", offset_cal, flags[1]);
    check("overrange_enable", overrange_enable, flags[0]);
    check("cal_run", 9'(busy_cnt - b0), 9'h020);
    check("state", u_css_link_if.link_state, css_link_data);
    check("link_up", link_up, 9'h001);
    // released request on the chosen path
    if (flags[4]) check("ts", {u_css_link_if.ts_p, u_css_link_if.ts_n},
                        9'h002);
    else check("se", u_css_link_if.sync_se_n, 9'h001);
    @(negedge core_clk) adc_over = 1'b1;
    repeat (2) @(negedge core_clk);
    check("ovr_flag", overrange_flag, flags[0]);
    adc_over = 1'b0;
    @(negedge core_clk) rx_resync = 1'b1;
    @(negedge core_clk) rx_resync = 1'b0;
    for (n = 0; n < 10 && link_up !== 1'b0; n++) @(negedge core_clk);
    check("resync_drop", link_up, 9'h000);
    for (n = 0; n < 60 && link_up !== 1'b1; n++) @(negedge core_clk);
    check("relink", link_up, 9'h001);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset_n, clock_stable, start, rx_resync, adc_over} = 5'h00;
    {cfg_link_mode, cfg_frames} = 14'h0000;
    {cfg_sync_select, cfg_single_channel, cfg_background} = 3'h0;
    {cfg_offset, cfg_overrange} = 2'h0;
    {err_total, checked, cycles, busy_cnt} = {4{32'sd0}};
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    // clock is stable before the host may begin
    clock_stable = 1'b1;
    run_seq(5'h0a, 9'h010, 5'b01101);
    $display("test 1 done");
    run_seq(5'h13, 9'h100, 5'b10010);
    $display("test 2 done");
    run_seq(5'h1f, 9'h001, 5'b00000);
    $display("test 3 done");
    stop_test();
  end
endmodule // converter_startup_sequencer_test
`default_nettype wire
